// >>> bench/ccs_top_asserts.sv
// port assertions for the cpu clock source block
`timescale 1ns/100ps
`default_nettype none
module ccs_chk (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic CPU_CLK,
  input wire logic HALF_CLOCK_TICK,
  input wire logic PLL_POWER_ON,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_single: assert property (s_req |=> s_ack)
    else $error("ack not one pulse after request");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("ack without request");
  a_data_width: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_tick_edge: assert property (HALF_CLOCK_TICK |-> CPU_CLK != $past(CPU_CLK))
    else $error("tick without cpu clock edge");
  a_edge_tick: assert property ($changed(CPU_CLK) |-> HALF_CLOCK_TICK)
    else $error("cpu clock edge without tick");
  a_irq_pll_on: assert property (IRQ |-> PLL_POWER_ON)
    else $error("failure flagged with pll off");
  a_irq_clock_moves: assert property ($rose(IRQ) |-> ##[1:12] HALF_CLOCK_TICK)
    else $error("no cpu clock after switchover");
  a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(WB_ACK_O))
    else $error("irq dropped without bus access");
  a_pll_after_rst: assert property ($rose(RST_B) |-> ##[0:2] PLL_POWER_ON)
    else $error("supervisor not enabled after reset");
endmodule
`default_nettype wire

// >>> bench/ccs_xtal.sv
// behavioural crystal oscillator, period set by the bench, can be stopped
`timescale 1ns/100ps
`default_nettype none
module ccs_xtal (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half_cycles,
  output logic xtal
);
  logic lvl = 1'b0;
  int cnt = 0;
  assign xtal = lvl;
  // a dead crystal freezes at its last level, which is what the supervisor must catch
  always @(posedge clk) begin
    if (run) begin
      if (cnt >= half_cycles - 1) begin
        cnt <= 0;
        lvl <= ~lvl;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_cpu_clock_source_and_osc_watchdog.sv
// testbench for the cpu clock source and oscillator supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_clock_source_and_osc_watchdog;
  logic CLK, RST_B, BIDIR_RESET_REQ, WB_CYC_I, WB_STB_I, WB_WE_I, run;
  logic [3:0] WB_ADR_I, WB_SEL_I;
  logic [31:0] WB_DAT_I, q;
  logic [2:0] straps;
  logic [7:0] hp;
  wire [31:0] WB_DAT_O;
  wire WB_ACK_O, CPU_CLK, HALF_CLOCK_TICK, PLL_POWER_ON, IRQ, xtal;
  int errors, num_checks, t, n;
  // state byte expected per strap code: {pll on, straps, one-hot mode}
  logic [7:0] ex [8] = '{8'h84, 8'h91, 8'hA4, 8'hB2, 8'hC4, 8'hD4, 8'hE4, 8'hF4};
  ccs_top dut_u (.CLK(CLK), .RST_B(RST_B), .CRYSTAL_INPUT_PIN(xtal), .CLOCK_SELECT_STRAP_PINS(straps),
    .BIDIR_RESET_REQ(BIDIR_RESET_REQ), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .CPU_CLK(CPU_CLK), .HALF_CLOCK_TICK(HALF_CLOCK_TICK), .PLL_POWER_ON(PLL_POWER_ON), .IRQ(IRQ));
  ccs_xtal xtal_u (.clk(CLK), .run(run), .half_cycles(hp), .xtal(xtal));
  task close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkn(input string nm, input int e, input int g);
    num_checks++;
    if (g < e - 1 || g > e + 1) begin
      errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out;
    end
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  task rst(input logic [2:0] s);
    RST_B <= 1'b0;
    straps <= s;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge CLK);
  endtask
  task cnt(input int c);
    t = 0;
    repeat (c) begin
      @(posedge CLK);
      if (HALF_CLOCK_TICK === 1'b1) t++;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    {RST_B, BIDIR_RESET_REQ, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, straps} = '0;
    WB_SEL_I = 4'h1;
    run = 1'b1;
    hp = 8'h08;
    errors = 0;
    num_checks = 0;
    for (int i = 0; i < 8; i++) begin
      rst(3'(i));
      wb(1'b0, 4'hC, 32'h0);
      chk("state", ex[i], q[7:0]);
    end
    hp <= 8'h0C;
    rst(3'h1);
    cnt(240);
    chkn("prescale ticks", 10, t);
    hp <= 8'h08;
    rst(3'h3);
    cnt(240);
    chkn("direct ticks", 30, t);
    wb(1'b0, 4'h0, 32'h0);
    chk("config", 8'h00, q[7:0]);
    wb(1'b1, 4'h8, 32'h1);
    run <= 1'b0;
    n = 0;
    while (IRQ !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 400) begin
      errors++;
      close_out;
    end
    chk("fail delay", 8'h01, {7'h0, n > 110 && n < 150});
    // crystal comes back but the clock must not return to it
    run <= 1'b1;
    repeat (100) @(posedge CLK);
    wb(1'b0, 4'hC, 32'h0);
    chk("failed state", 8'hB8, q[7:0]);
    cnt(80);
    chkn("failover ticks", 20, t);
    wb(1'b0, 4'h4, 32'h0);
    chk("status", 8'h01, q[7:0]);
    wb(1'b0, 4'h4, 32'h0);
    chk("status clear", 8'h00, q[7:0]);
    chk("irq", 8'h00, {7'h0, IRQ});
    BIDIR_RESET_REQ <= 1'b1;
    @(posedge CLK);
    BIDIR_RESET_REQ <= 1'b0;
    repeat (4) @(posedge CLK);
    wb(1'b0, 4'hC, 32'h0);
    chk("restored", 8'hB2, q[7:0]);
    wb(1'b1, 4'h0, 32'h10);
    wb(1'b0, 4'h0, 32'h0);
    chk("config", 8'h10, q[7:0]);
    chk("pll power", 8'h00, {7'h0, PLL_POWER_ON});
    run <= 1'b0;
    repeat (300) @(posedge CLK);
    wb(1'b0, 4'h4, 32'h0);
    chk("status off", 8'h00, q[7:0]);
    chk("cpu clock", {7'h0, xtal}, {7'h0, CPU_CLK});
    run <= 1'b1;
    rst(3'h0);
    repeat (500) @(posedge CLK);
    cnt(240);
    chkn("pll ticks", 120, t);
    run <= 1'b0;
    repeat (300) @(posedge CLK);
    wb(1'b0, 4'h4, 32'h0);
    chk("status pll", 8'h00, q[7:0]);
    close_out;
  end
endmodule
bind ccs_top ccs_chk chk_u (.CLK(CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .CPU_CLK(CPU_CLK), .HALF_CLOCK_TICK(HALF_CLOCK_TICK),
  .PLL_POWER_ON(PLL_POWER_ON), .IRQ(IRQ));
`default_nettype wire

// >>> rtl/ccs_defines.vh
// constants for the cpu clock source and oscillator supervisor
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_ADR_SYSCFG 2'h0
`define CCS_ADR_STATUS 2'h1
`define CCS_ADR_MASK 2'h2
`define CCS_ADR_STATE 2'h3
`define CCS_WDDIS_BIT 4
`define CCS_RST_SYSCFG 8'h00
`define CCS_STRAP_PRESCALE 3'h1
`define CCS_STRAP_DIRECT 3'h3
`define CCS_PLL_F_000 5'h04
`define CCS_PLL_F_010 5'h03
`define CCS_PLL_F_100 5'h02
`define CCS_PLL_F_101 5'h05
`define CCS_PLL_F_110 5'h01
`define CCS_PLL_F_111 5'h0A
`define CCS_FREE_DIV 4'h4
`define CCS_WD_OVERFLOW 5'h10
`define CCS_HP_INIT 16'h0010
`define CCS_HP_MAX 16'hFFFF
`endif

// >>> rtl/ccs_supervisor.v
// oscillator supervisor counter: counts free-running clock rises (every second tick) between crystal edges
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"
module ccs_supervisor (
  input wire clk,
  input wire rst_b,
  input wire enable,
  input wire xtal_edge,
  input wire free_rise,
  output reg fail
);
  reg [4:0] count_q;
  reg [4:0] count_d;
  reg fail_d;

  always @* begin
    count_d = count_q;
    fail_d = 1'b0;
    if (!enable || xtal_edge) begin
      count_d = 5'h00;
    end else if (free_rise) begin
      if (count_q == (`CCS_WD_OVERFLOW - 5'h01)) begin
        count_d = 5'h00;
        fail_d = 1'b1;
      end else begin
        count_d = count_q + 5'h01;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      count_q <= 5'h00;
      fail <= 1'b0;
    end else begin
      count_q <= count_d;
      fail <= fail_d;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ccs_top.v
// cpu clock source selection, pll model and oscillator supervision with wishbone registers
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"
module ccs_top (
  input wire CLK,
  input wire RST_B,
  input wire CRYSTAL_INPUT_PIN,
  input wire [2:0] CLOCK_SELECT_STRAP_PINS,
  input wire BIDIR_RESET_REQ,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg CPU_CLK,
  output reg HALF_CLOCK_TICK,
  output reg PLL_POWER_ON,
  output reg IRQ
);
  localparam MODE_PRESCALE = 4'b0001;
  localparam MODE_DIRECT = 4'b0010;
  localparam MODE_PLL = 4'b0100;
  localparam MODE_FAILED = 4'b1000;

  reg [1:0] xtal_sync_q;
  reg xtal_prev_q;
  reg [2:0] clock_select_straps_q;
  reg [4:0] pll_factor;
  reg [3:0] mode_q;
  reg [3:0] mode_d;
  reg [7:0] system_config_register_q;
  reg osc_fail_flag_q;
  reg osc_fail_mask_q;
  reg [3:0] free_div_q;
  reg free_clk_q;
  reg switch_armed_q;
  reg [15:0] hp_meas_q;
  reg [15:0] hp_q;
  reg [4:0] xtal_trans_q;
  reg [15:0] phase_q;
  reg cpu_clk_d;
  wire xtal_edge;
  wire xtal_rise;
  wire free_tick;
  wire free_rise;
  wire osc_watchdog_disable;
  wire supervisor_en;
  wire osc_fail;
  wire wb_req;
  wire [15:0] phase_sum;
  wire [2:0] strap_sync;
  wire wb_wr;
  wire wb_rd;
  wire [1:0] wb_word;
  wire [7:0] state_word;
  wire fail_event;

  // only the second flop feeds logic; runs through reset, so release brings no false edge
  always @(posedge CLK) begin
    xtal_sync_q <= {xtal_sync_q[0], CRYSTAL_INPUT_PIN};
    xtal_prev_q <= xtal_sync_q[1];
  end
  assign xtal_edge = xtal_sync_q[1] ^ xtal_prev_q;
  assign xtal_rise = xtal_sync_q[1] & ~xtal_prev_q;

  // strap synchroniser runs during reset too, so the capture sees settled pin levels
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap_sync
      reg s1_q;
      reg s2_q;
      always @(posedge CLK) begin
        s1_q <= CLOCK_SELECT_STRAP_PINS[gi];
        s2_q <= s1_q;
      end
      assign strap_sync[gi] = s2_q;
    end
  endgenerate

  // straps keep their last reset-time value; software resets leave them alone
  always @(posedge CLK) begin
    if (!RST_B) begin
      clock_select_straps_q <= strap_sync;
    end
  end

  // the two non-pll codes fall to the default and never reach the pll
  always @* begin
    case (clock_select_straps_q)
      3'h0: pll_factor = `CCS_PLL_F_000;
      3'h2: pll_factor = `CCS_PLL_F_010;
      3'h4: pll_factor = `CCS_PLL_F_100;
      3'h5: pll_factor = `CCS_PLL_F_101;
      3'h6: pll_factor = `CCS_PLL_F_110;
      default: pll_factor = `CCS_PLL_F_111;
    endcase
  end

  assign osc_watchdog_disable = system_config_register_q[`CCS_WDDIS_BIT];
  assign supervisor_en = ((mode_q == MODE_PRESCALE) || (mode_q == MODE_DIRECT))
    && !osc_watchdog_disable;

  // free-running pll model: a tick per divider wrap, level toggles on each tick
  always @(posedge CLK) begin
    if (!RST_B) begin
      free_div_q <= 4'h0;
      free_clk_q <= 1'b0;
    end else if (!PLL_POWER_ON) begin
      free_div_q <= 4'h0;
      free_clk_q <= 1'b0;
    end else if (free_tick) begin
      free_div_q <= 4'h0;
      free_clk_q <= ~free_clk_q;
    end else begin
      free_div_q <= free_div_q + 4'h1;
    end
  end
  assign free_tick = PLL_POWER_ON && (free_div_q == (`CCS_FREE_DIV - 4'h1));
  assign free_rise = free_tick && !free_clk_q;

  // crystal must run below a quarter of CLK, or its edges merge in the synchroniser
  ccs_supervisor u_supervisor (
    .clk(CLK),
    .rst_b(RST_B),
    .enable(supervisor_en),
    .xtal_edge(xtal_edge),
    .free_rise(free_rise),
    .fail(osc_fail)
  );

  // failure state only leaves through reset, hardware or bidirectional
  always @* begin
    mode_d = mode_q;
    case (mode_q)
      MODE_PRESCALE,
      MODE_DIRECT: begin
        if (osc_fail && supervisor_en) begin
          mode_d = MODE_FAILED;
        end
      end
      MODE_PLL: mode_d = MODE_PLL;
      MODE_FAILED: mode_d = MODE_FAILED;
      default: mode_d = MODE_DIRECT;
    endcase
  end

  // bidirectional reset reselects the captured strap mode; it has no work to do in pll mode
  always @(posedge CLK) begin
    if (!RST_B || (BIDIR_RESET_REQ && (mode_q != MODE_PLL))) begin
      if (clock_select_straps_q == `CCS_STRAP_PRESCALE) begin
        mode_q <= MODE_PRESCALE;
      end else if (clock_select_straps_q == `CCS_STRAP_DIRECT) begin
        mode_q <= MODE_DIRECT;
      end else begin
        mode_q <= MODE_PLL;
      end
    end else begin
      mode_q <= mode_d;
    end
  end

  // pll model: half-period estimate steps by one count per F crystal transitions
  assign phase_sum = phase_q + {11'h000, pll_factor};
  always @(posedge CLK) begin
    if (!RST_B) begin
      hp_meas_q <= 16'h0000;
      hp_q <= `CCS_HP_INIT;
      xtal_trans_q <= 5'h00;
    end else if (mode_q == MODE_PLL) begin
      if (xtal_edge) begin
        // the edge cycle itself belongs to the next half period
        hp_meas_q <= 16'h0001;
        if (xtal_trans_q >= (pll_factor - 5'h01)) begin
          xtal_trans_q <= 5'h00;
          if (hp_meas_q > hp_q) begin
            hp_q <= hp_q + 16'h0001;
          end else if ((hp_meas_q < hp_q) && (hp_q > 16'h0001)) begin
            hp_q <= hp_q - 16'h0001;
          end
        end else begin
          xtal_trans_q <= xtal_trans_q + 5'h01;
        end
      end else if (hp_meas_q != `CCS_HP_MAX) begin
        hp_meas_q <= hp_meas_q + 16'h0001;
      end
    end
  end

  always @* begin
    cpu_clk_d = CPU_CLK;
    case (mode_q)
      MODE_PRESCALE: begin
        if (xtal_rise) begin
          cpu_clk_d = ~CPU_CLK;
        end
      end
      // resynchronised level, three CLK behind the pin
      MODE_DIRECT: cpu_clk_d = xtal_sync_q[1];
      MODE_PLL: begin
        if (phase_sum >= hp_q) begin
          cpu_clk_d = ~CPU_CLK;
        end
      end
      MODE_FAILED: begin
        // first tick after the switch only arms, so no pulse is shorter than a tick
        if (free_tick && switch_armed_q) begin
          cpu_clk_d = ~CPU_CLK;
        end
      end
      default: cpu_clk_d = CPU_CLK;
    endcase
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      phase_q <= 16'h0000;
    end else if (mode_q != MODE_PLL) begin
      phase_q <= 16'h0000;
    end else if (phase_sum >= hp_q) begin
      phase_q <= phase_sum - hp_q;
    end else begin
      phase_q <= phase_sum;
    end
  end

  // level and edge pulse leave the same flop stage, so the pulse marks the cycle of the new level
  always @(posedge CLK) begin
    if (!RST_B) begin
      CPU_CLK <= 1'b0;
      HALF_CLOCK_TICK <= 1'b0;
    end else begin
      CPU_CLK <= cpu_clk_d;
      HALF_CLOCK_TICK <= cpu_clk_d ^ CPU_CLK;
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      switch_armed_q <= 1'b0;
    end else if (mode_q != MODE_FAILED) begin
      switch_armed_q <= 1'b0;
    end else if (free_tick) begin
      switch_armed_q <= 1'b1;
    end
  end

  // the free-running pll is needed whenever the supervisor or the failover clock is
  always @(posedge CLK) begin
    if (!RST_B) begin
      PLL_POWER_ON <= 1'b0;
    end else begin
      PLL_POWER_ON <= (mode_q == MODE_PLL) || (mode_q == MODE_FAILED)
        || !osc_watchdog_disable;
    end
  end

  // wishbone slave: registered ack one cycle after the request, so every access takes two cycles
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_word = WB_ADR_I[3:2];
  assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
  assign wb_rd = wb_req && !WB_WE_I;
  assign state_word = {PLL_POWER_ON, clock_select_straps_q, mode_q};
  assign fail_event = osc_fail && supervisor_en;

  always @(posedge CLK) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      system_config_register_q <= `CCS_RST_SYSCFG;
      osc_fail_mask_q <= 1'b0;
    end else if (wb_wr) begin
      if (wb_word == `CCS_ADR_SYSCFG) begin
        system_config_register_q <= WB_DAT_I[7:0];
      end
      if (wb_word == `CCS_ADR_MASK) begin
        osc_fail_mask_q <= WB_DAT_I[0];
      end
    end
  end

  // read data holds between reads, so a late look still sees the last answer
  always @(posedge CLK) begin
    if (!RST_B) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (wb_rd) begin
      case (wb_word)
        `CCS_ADR_SYSCFG: WB_DAT_O <= {24'h00_0000, system_config_register_q};
        `CCS_ADR_STATUS: WB_DAT_O <= {31'h0000_0000, osc_fail_flag_q};
        `CCS_ADR_MASK: WB_DAT_O <= {31'h0000_0000, osc_fail_mask_q};
        default: WB_DAT_O <= {24'h00_0000, state_word};
      endcase
    end
  end

  // a new failure beats the clear-on-read, so no event is lost to a racing status read
  always @(posedge CLK) begin
    if (!RST_B) begin
      osc_fail_flag_q <= 1'b0;
    end else if (fail_event) begin
      osc_fail_flag_q <= 1'b1;
    end else if (wb_rd && (wb_word == `CCS_ADR_STATUS)) begin
      osc_fail_flag_q <= 1'b0;
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= osc_fail_flag_q && osc_fail_mask_q;
    end
  end
endmodule
`default_nettype wire
